// file: src/frc_top.sv
// Purpose: control and status logic of the fixed voltage reference
// Assumes: AXI4-Lite slave, one clock, synchronous active-high reset
// Notes:   analog settle is modelled by a counter plus an analog flag
// Summary of operation
// - enable bit 7 powers the reference
// - ready set after circuits have settled
// - ready reads zero when off or settling
// - one variant reads ready always one
// - bits 3-2 select comparator path gain
// - bits 1-0 select ADC path gain
// - both gain paths programmed independently
// - bit 5 enables temperature indicator
// - bit 4 selects temperature high range
// - writable bits reset to zero
// - fast internal oscillator forces reference on while awake
// - brown-out mode 11 forces reference on; modes 01 and 10 only with the fast bit set
// - regulator mode awake forces reference on when the variant strap is set
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // variant strap and analog settled status
  input  wire logic        variantAlwaysReady,
  input  wire logic        analogSettled,
  // axi write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // axi write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // axi read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // analog controls
  output logic             refPowerOn_r,
  output logic             adcAmpOn_r,
  output logic [2:0]       adcGain_r,
  output logic             cdaAmpOn_r,
  output logic [2:0]       cdaGain_r,
  output logic             tempSenseOn_r,
  output logic             tempRangeHigh_r
);
  import frc_pkg::*;

  // ==================================================================
  // declarations
  logic [7:0]       ctrl_r;         // writable control bits
  logic [11:0]      sysCfg_r;       // oscillator, brown-out, regulator
  logic             awHeld_r;       // write address captured
  logic [11:0]      awAddr_r;       // captured write address
  logic             wHeld_r;        // write data captured
  logic [31:0]      wData_r;        // captured write data
  logic [3:0]       wStrb_r;        // captured byte strobes
  frc_state_t       state_r;        // settle state
  frc_state_t       state_nxt;      // next settle state
  logic [`FRC_CNT_W-1:0] settleCnt_r; // settle cycles elapsed
  logic             settledSync1_r; // synchroniser stage one
  logic             settledSync2_r; // synchroniser stage two
  logic             variantSync1_r; // strap synchroniser stage one
  logic             variantSync2_r; // strap synchroniser stage two
  logic             readyBit;       // ready flag as software sees it
  logic             forceOn;        // some other block needs the ref
  logic             refOn;          // reference requested on
  logic             doWrite;        // both halves of a write present
  logic [7:0]       ctrlRead;       // control register read image
  logic [31:0]      rdMux;          // read data mux

  localparam logic [`FRC_CNT_W-1:0] SETTLE_CYC =
    `FRC_CNT_W'(`FRC_SETTLE_CYC);

  // ==================================================================
  // pin inputs: two flops before any logic reads them
  always_ff @(posedge clock) begin
    if (rst) begin
      settledSync1_r <= 1'b0;
      settledSync2_r <= 1'b0;
      variantSync1_r <= 1'b0;
      variantSync2_r <= 1'b0;
    end else begin
      settledSync1_r <= analogSettled;
      settledSync2_r <= settledSync1_r;
      variantSync1_r <= variantAlwaysReady;
      variantSync2_r <= variantSync1_r;
    end
  end

  // ==================================================================
  // force-on terms from other blocks' settings
  always_comb begin
    forceOn = 1'b0;
    if (sysCfg_r[`FRC_SYS_OSC_HI:`FRC_SYS_OSC_LO] == `FRC_OSC_INTERNAL &&
        sysCfg_r[`FRC_SYS_FREQ_HI:`FRC_SYS_FREQ_LO+1] == `FRC_FREQ_FAST &&
        !sysCfg_r[`FRC_SYS_SLEEP]) begin
      forceOn = 1'b1;
    end
    case (sysCfg_r[`FRC_SYS_BOR_HI:`FRC_SYS_BOR_LO])
      2'b11:   forceOn = 1'b1;
      2'b10,
      2'b01:   begin
        if (sysCfg_r[`FRC_SYS_BOR_FAST]) begin
          forceOn = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // regulator awake; variant strap marks regulated part
    if (variantSync2_r && sysCfg_r[`FRC_SYS_REG_PM] &&
        !sysCfg_r[`FRC_SYS_SLEEP]) begin
      forceOn = 1'b1;
    end
  end

  assign refOn = ctrl_r[`FRC_BIT_ENABLE] | forceOn;

  // ==================================================================
  // settle state machine: counts minimum time, then waits analog flag
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FRC_ST_OFF: begin
        if (refOn) begin
          state_nxt = FRC_ST_SETTLE;
        end
      end
      FRC_ST_SETTLE: begin
        if (!refOn) begin
          state_nxt = FRC_ST_OFF;
        end else if (settleCnt_r >= SETTLE_CYC && settledSync2_r) begin
          state_nxt = FRC_ST_READY;
        end
      end
      FRC_ST_READY: begin
        if (!refOn || !settledSync2_r) begin
          state_nxt = refOn ? FRC_ST_SETTLE : FRC_ST_OFF;
        end
      end
      default: state_nxt = FRC_ST_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= FRC_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // settle counter, held at its bound so it never wraps
  always_ff @(posedge clock) begin
    if (rst || state_r != FRC_ST_SETTLE) begin
      settleCnt_r <= '0;
    end else if (settleCnt_r < SETTLE_CYC) begin
      settleCnt_r <= settleCnt_r + 1'b1;
    end
  end

  // zero unless ready; variant always one
  assign readyBit = variantSync2_r | (state_r == FRC_ST_READY);

  // ==================================================================
  // axi write channel: address and data taken in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_r      <= 1'b0;
      awAddr_r      <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wHeld_r      <= 1'b0;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // write response: unmapped address answers slverr
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_r == `FRC_OFF_CTRL ||
                       awAddr_r == `FRC_OFF_SYSCFG ||
                       awAddr_r == `FRC_OFF_STATUS) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==================================================================
  // control register; reset zero
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `FRC_CTRL_RESET;
    end else if (doWrite && awAddr_r == `FRC_OFF_CTRL && wStrb_r[0]) begin
      ctrl_r <= wData_r[7:0] & `FRC_CTRL_WMASK;
    end
  end

  // system configuration mirror of oscillator, brown-out, regulator
  always_ff @(posedge clock) begin
    if (rst) begin
      sysCfg_r <= `FRC_SYS_RESET;
    end else if (doWrite && awAddr_r == `FRC_OFF_SYSCFG) begin
      if (wStrb_r[0]) begin
        sysCfg_r[7:0] <= wData_r[7:0];
      end
      if (wStrb_r[1]) begin
        sysCfg_r[11:8] <= wData_r[11:8];
      end
    end
  end

  // ==================================================================
  // read channel: one word, answered two cycles after arvalid
  always_comb begin
    ctrlRead = ctrl_r;
    ctrlRead[`FRC_BIT_READY] = readyBit;
  end

  always_comb begin
    case (s_axi_araddr)
      `FRC_OFF_CTRL:   rdMux = {24'h00_0000, ctrlRead};
      `FRC_OFF_SYSCFG: rdMux = {20'h0_0000, sysCfg_r};
      `FRC_OFF_STATUS: rdMux = {28'h000_0000, forceOn, refOn, state_r};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= (s_axi_araddr == `FRC_OFF_CTRL ||
                         s_axi_araddr == `FRC_OFF_SYSCFG ||
                         s_axi_araddr == `FRC_OFF_STATUS) ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==================================================================
  // analog control outputs, all registered
  always_ff @(posedge clock) begin
    if (rst) begin
      refPowerOn_r    <= 1'b0;
      tempSenseOn_r   <= 1'b0;
      tempRangeHigh_r <= 1'b0;
    end else begin
      refPowerOn_r    <= refOn;
      tempSenseOn_r   <= ctrl_r[`FRC_BIT_TEMP_EN];
      tempRangeHigh_r <= ctrl_r[`FRC_BIT_TEMP_RNG];
    end
  end

  frc_gain_path adcPath (
    .clock        (clock),
    .rst          (rst),
    .refOn        (refOn),
    .gainSel      (frc_gain_t'(ctrl_r[`FRC_ADC_HI:`FRC_ADC_LO])),
    .ampOn_r      (adcAmpOn_r),
    .gainOneHot_r (adcGain_r)
  );

  frc_gain_path cdaPath (
    .clock        (clock),
    .rst          (rst),
    .refOn        (refOn),
    .gainSel      (frc_gain_t'(ctrl_r[`FRC_CDA_HI:`FRC_CDA_LO])),
    .ampOn_r      (cdaAmpOn_r),
    .gainOneHot_r (cdaGain_r)
  );
endmodule

// file: src/frc_defs.svh
// Purpose: constants for the fixed reference control block
// Assumes: included by bare name, guarded against double inclusion
// Notes:   offsets are byte addresses on the register bus
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

// ==================================================================
// register offsets
`define FRC_OFF_CTRL      12'h000
`define FRC_OFF_SYSCFG    12'h004
`define FRC_OFF_STATUS    12'h008

// ==================================================================
// control register fields
`define FRC_BIT_ENABLE    7
`define FRC_BIT_READY     6
`define FRC_BIT_TEMP_EN   5
`define FRC_BIT_TEMP_RNG  4
`define FRC_CDA_HI        3
`define FRC_CDA_LO        2
`define FRC_ADC_HI        1
`define FRC_ADC_LO        0
`define FRC_CTRL_RESET    8'h00
`define FRC_CTRL_WMASK    8'hBF

// ==================================================================
// system configuration fields
`define FRC_SYS_OSC_HI    2
`define FRC_SYS_OSC_LO    0
`define FRC_SYS_FREQ_HI   6
`define FRC_SYS_FREQ_LO   3
`define FRC_SYS_BOR_HI    8
`define FRC_SYS_BOR_LO    7
`define FRC_SYS_BOR_FAST  9
`define FRC_SYS_REG_PM    10
`define FRC_SYS_SLEEP     11
`define FRC_SYS_RESET     12'h000
`define FRC_OSC_INTERNAL  3'h4
`define FRC_FREQ_FAST     3'h0

// ==================================================================
// timing: settle time of the analog circuits
`define FRC_SETTLE_NS     25
`define FRC_CLK_NS        5
`define FRC_SETTLE_CYC    ((`FRC_SETTLE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_CNT_W         8

`endif

// file: src/frc_pkg.sv
// Purpose: types for the fixed reference control block
// Assumes: nothing beyond the defs header
// Notes:   gain encodings shared by both amplifier paths
package frc_pkg;
  // gain select of one amplifier path
  typedef enum logic [1:0] {
    FRC_GAIN_OFF = 2'b00,
    FRC_GAIN_1X  = 2'b01,
    FRC_GAIN_2X  = 2'b10,
    FRC_GAIN_4X  = 2'b11
  } frc_gain_t;
  // settling state
  typedef enum logic [1:0] {
    FRC_ST_OFF    = 2'b00,
    FRC_ST_SETTLE = 2'b01,
    FRC_ST_READY  = 2'b10
  } frc_state_t;
endpackage

// file: src/frc_gain_path.sv
// Purpose: decode of one amplifier path gain select
// Assumes: reference enable gates the path
// Notes:   one instance per amplifier, paths fully independent
`timescale 1ns/1ps
module frc_gain_path (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // control
  input  wire logic              refOn,
  input  wire frc_pkg::frc_gain_t gainSel,
  // amplifier controls
  output logic                   ampOn_r,
  output logic [2:0]             gainOneHot_r
);
  import frc_pkg::*;

  // ==================================================================
  // registered decode: 1x, 2x, 4x one-hot, off when 00 or ref off
  always_ff @(posedge clock) begin
    if (rst) begin
      ampOn_r      <= 1'b0;
      gainOneHot_r <= 3'h0;
    end else begin
      ampOn_r <= refOn && (gainSel != FRC_GAIN_OFF);
      case (gainSel)
        FRC_GAIN_1X: gainOneHot_r <= refOn ? 3'h1 : 3'h0;
        FRC_GAIN_2X: gainOneHot_r <= refOn ? 3'h2 : 3'h0;
        FRC_GAIN_4X: gainOneHot_r <= refOn ? 3'h4 : 3'h0;
        default:     gainOneHot_r <= 3'h0;
      endcase
    end
  end
endmodule

// file: tb/frc_top_asserts.sv
// Purpose: concurrent checks on the fixed reference control top
// Assumes: bound to frc_top, one clock, sync active-high reset
// Notes:   looks at both sides of the bus handshakes and at the analog controls
`timescale 1ns/1ps
module frc_top_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // analog controls
  input wire logic        refPowerOn_r,
  input wire logic        adcAmpOn_r,
  input wire logic [2:0]  adcGain_r,
  input wire logic        cdaAmpOn_r,
  input wire logic [2:0]  cdaGain_r,
  input wire logic        tempSenseOn_r,
  input wire logic        tempRangeHigh_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // steps of a transfer
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // reference low on two edges in a row, gain paths have caught up
  sequence ref_off2;
    !refPowerOn_r ##1 !refPowerOn_r;
  endsequence
  // ==========================================================
  // bus timing
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after take");
  wresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before accepted");
  // ==========================================================
  // analog controls
  gain_off_a: assert property (ref_off2 |-> adcGain_r == 3'h0 &&
    cdaGain_r == 3'h0 && !adcAmpOn_r && !cdaAmpOn_r)
    else $error("gain path live with reference off");
  gain_onehot_a: assert property ($onehot0(adcGain_r) &&
    $onehot0(cdaGain_r))
    else $error("gain select not one-hot");
  amp_match_a: assert property (
    adcAmpOn_r == (adcGain_r != 3'h0) && cdaAmpOn_r == (cdaGain_r != 3'h0))
    else $error("amplifier enable disagrees with gain");
  temp_cause_a: assert property (
    $changed(tempSenseOn_r) || $changed(tempRangeHigh_r) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("temperature control moved without a write");
endmodule

bind frc_top frc_top_asserts u_chk (.*);

// file: tb/frc_top_bench.sv
// Purpose: self-checking bench for the fixed reference control top
// Assumes: bus master tasks below, one request outstanding at a time
// Notes:   expected reads and responses queued, compared by a monitor
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_top_bench;
  import frc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        clock = 0, rst = 1, varRdy = 0, settled = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tmp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        refPowerOn_r, adcAmpOn_r, cdaAmpOn_r;
  logic        tempSenseOn_r, tempRangeHigh_r;
  logic [2:0]  adcGain_r, cdaGain_r;
  logic [33:0] rQ[$];
  logic [1:0]  bQ[$];
  int          badCount = 0, nChecks = 0;
  // {strap, forced, syscfg}
  logic [13:0] forceTab [12] = '{14'h1004, 14'h100C, 14'h0014, 14'h0804,
    14'h1180, 14'h0100, 14'h1300, 14'h1280, 14'h0080, 14'h3400, 14'h2C00,
    14'h0400};
  wire  [10:0] pins = {refPowerOn_r, tempSenseOn_r, tempRangeHigh_r,
    adcAmpOn_r, adcGain_r, cdaAmpOn_r, cdaGain_r};

  always #2.5 clock = ~clock;

  frc_top u_dut (.clock(clock), .rst(rst), .variantAlwaysReady(varRdy),
    .analogSettled(settled), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .refPowerOn_r(refPowerOn_r), .adcAmpOn_r(adcAmpOn_r),
    .adcGain_r(adcGain_r), .cdaAmpOn_r(cdaAmpOn_r), .cdaGain_r(cdaGain_r),
    .tempSenseOn_r(tempSenseOn_r), .tempRangeHigh_r(tempRangeHigh_r));

  // ==========================================================
  // reporting and comparison
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail(input string m);
    badCount++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
    nChecks++;
    if (g !== e) fail("read word or status differs");
  endtask
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    nChecks++;
    if (g !== e) fail("write status differs");
  endtask
  task automatic cmp_pin(input logic [10:0] g, input logic [10:0] e);
    nChecks++;
    if (g !== e) fail("analog control pins differ");
  endtask
  // expected {amp on, one-hot gain} of one path
  function automatic logic [3:0] amp(input logic [1:0] g);
    amp = (g == 2'b00) ? 4'h0 : {1'b1, 3'h1 << (g - 2'd1)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ==========================================================
  // bus master: answer ready offered with the request and held until
  // the answer is seen; each valid dropped at the edge it is taken
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    int   n;
    logic dn;
    n = 0;
    dn = 0;
    if (wr) bQ.push_back(e[33:32]);
    else rQ.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (!dn && n < 60) begin
      @(posedge clock);
      n++;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    // one idle edge, so a following call never raises a ready in the
    // same time step in which this one lowered it
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clock);
    if (!dn) begin
      fail("bus transfer timed out");
      report_and_stop();
    end
  endtask

  // monitor: oldest note against each accepted answer
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (rQ.size() == 0) fail("read answer nobody asked for");
      else cmp_rd({s_axi_rresp, s_axi_rdata}, rQ.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (bQ.size() == 0) fail("write answer nobody asked for");
      else cmp_b(s_axi_bresp, bQ.pop_front());
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(2));
    tick(3);
    rst <= 1'b0;
    tick(1);
    bus(0, `FRC_OFF_CTRL, 0, 0);
    bus(0, `FRC_OFF_SYSCFG, 0, 0);
    cmp_pin(pins, 11'h000);
    bus(0, 12'h00C, 0, {2'b10, 32'h0});
    bus(1, 12'h00C, 32'h0000_00FF, {2'b10, 32'h0});
    // enable without settled analog: power on, ready held low
    bus(1, `FRC_OFF_CTRL, 32'h0000_0080, 0);
    tick(20);
    cmp_pin({pins[10], 10'h0}, {1'b1, 10'h0});
    bus(0, `FRC_OFF_CTRL, 0, {2'b00, 32'h0000_0080});
    settled <= 1'b1;
    tick(12);
    bus(0, `FRC_OFF_CTRL, 0, {2'b00, 32'h0000_00C0});
    settled <= 1'b0;
    tick(6);
    bus(0, `FRC_OFF_CTRL, 0, {2'b00, 32'h0000_0080});
    // ready bit written with enable cleared has no effect
    bus(1, `FRC_OFF_CTRL, 32'h0000_0040, 0);
    settled <= 1'b1;
    tick(12);
    cmp_pin(pins, 11'h000);
    bus(0, `FRC_OFF_CTRL, 0, 0);
    // every gain pair with random temperature bits
    for (int i = 0; i < 16; i++) begin
      tmp = 2'($urandom);
      bus(1, `FRC_OFF_CTRL, {24'h0, 2'b10, tmp, 4'(i)}, 0);
      tick(2);
      cmp_pin(pins, {1'b1, tmp, amp(2'(i)), amp(2'(i >> 2))});
    end
    bus(1, `FRC_OFF_CTRL, 0, 0);
    // force-on table with enable low
    for (int k = 0; k < 12; k++) begin
      varRdy <= forceTab[k][13];
      bus(1, `FRC_OFF_SYSCFG, {20'h0, forceTab[k][11:0]}, 0);
      tick(2);
      cmp_pin({pins[10], 10'h0}, {forceTab[k][12], 10'h0});
    end
    varRdy <= 1'b1;
    bus(1, `FRC_OFF_SYSCFG, 0, 0);
    tick(4);
    bus(0, `FRC_OFF_CTRL, 0, {2'b00, 32'h0000_0040});
    // second reset in mid-run clears the writable bits
    varRdy <= 1'b0;
    bus(1, `FRC_OFF_CTRL, 32'h0000_00BF, 0);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
    bus(0, `FRC_OFF_CTRL, 0, 0);
    cmp_pin(pins, 11'h000);
    report_and_stop();
  end
endmodule
